// file: common/lvm_pkg.sv
`default_nettype none
package lvm_pkg;
  // ---------------------------------------------------------------
  // Special-purpose data memory addresses
  // ---------------------------------------------------------------
  localparam int LVM_AW = 8;
  localparam logic [7:0] LVM_ADDR_CTL = 8'h00;
  localparam logic [7:0] LVM_ADDR_EDGE = 8'h01;
  localparam logic [7:0] LVM_ADDR_PRI_A = 8'h02;
  localparam logic [7:0] LVM_ADDR_PRI_B = 8'h03;
  localparam logic [7:0] LVM_ADDR_PRI_C = 8'h04;
  localparam logic [7:0] LVM_ADDR_GRP_A = 8'h05;
  localparam logic [7:0] LVM_ADDR_GRP_B = 8'h06;
  localparam logic [7:0] LVM_ADDR_GRP_C = 8'h07;
  localparam logic [7:0] LVM_REG_RST = 8'h00;
  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int LVM_CTL_THR_LSB = 0;
  localparam int LVM_CTL_REFERENCE_OUTPUT_ENABLE_BIT = 3;
  localparam int LVM_CTL_EN_BIT = 4;
  localparam int LVM_CTL_LOW_VOLTAGE_OUT_FLAG_BIT = 5;
  localparam int LVM_EDGE_PIN0_LSB = 0;
  localparam int LVM_EDGE_PIN1_LSB = 2;
  localparam int LVM_PRI_A_GIE_BIT = 0;
  localparam int LVM_PRI_A_EN_LSB = 1;
  localparam int LVM_PRI_A_FLG_LSB = 4;
  localparam int LVM_ENA_LSB = 0;
  localparam int LVM_FLG_LSB = 4;
  localparam logic [2:0] LVM_THR_EXT = 3'h0;
  // ---------------------------------------------------------------
  // Edge select codes
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    LVM_EDGE_OFF = 2'b00,
    LVM_EDGE_RISE = 2'b01,
    LVM_EDGE_FALL = 2'b10,
    LVM_EDGE_BOTH = 2'b11
  } lvm_edge_t;
  // ---------------------------------------------------------------
  // Primary channels, index is also the vector number and priority
  // ---------------------------------------------------------------
  localparam int LVM_NPRI = 10;
  localparam int LVM_P_EXT_IRQ_PIN_0 = 0;
  localparam int LVM_P_EXT_IRQ_PIN_1 = 1;
  localparam int LVM_P_ADC = 2;
  localparam int LVM_P_MF0 = 3;
  localparam int LVM_P_SPI = 4;
  localparam int LVM_P_MF1 = 5;
  localparam int LVM_P_MF2 = 6;
  localparam int LVM_P_TB0 = 7;
  localparam int LVM_P_TB1 = 8;
  localparam int LVM_P_UART = 9;
  // ---------------------------------------------------------------
  // Event inputs from other peripherals
  // ---------------------------------------------------------------
  localparam int LVM_NSRC = 10;
  localparam int LVM_S_ADC = 0;
  localparam int LVM_S_SPI = 1;
  localparam int LVM_S_TB0 = 2;
  localparam int LVM_S_TB1 = 3;
  localparam int LVM_S_UART = 4;
  localparam int LVM_S_CTMP = 5;
  localparam int LVM_S_CTMA = 6;
  localparam int LVM_S_STMP = 7;
  localparam int LVM_S_STMA = 8;
  localparam int LVM_S_EEP = 9;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int LVM_CLK_PERIOD_NS = 20;
  localparam int LVM_T_IRQ_DELAY_US = 15;
  localparam int LVM_LV_DELAY_CYC =
    (LVM_T_IRQ_DELAY_US * 1000 + LVM_CLK_PERIOD_NS - 1) / LVM_CLK_PERIOD_NS;
  localparam int LVM_LV_CNT_W = 10;
endpackage
`default_nettype wire

// file: common/lvm_edge_if.sv
`timescale 1ns/1ps
`default_nettype none
interface lvm_edge_if;
  logic [3:0] edge_sel;
  logic [1:0] edge_hit;
  modport ctrl (output edge_sel, input edge_hit);
  modport det (input edge_sel, output edge_hit);
endinterface
`default_nettype wire

// file: rtl/lvm_edge_det.sv
`timescale 1ns/1ps
`default_nettype none
module lvm_edge_det (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // Pins
  input wire logic [1:0] i_ext_irq_pin,
  // Control side
  lvm_edge_if.det edge_bus
);
  import lvm_pkg::*;

  typedef struct packed {
    logic [1:0] s1;
    logic [1:0] s2;
    logic [1:0] prev;
    logic [1:0] hit;
  } lvm_edge_state_t;

  lvm_edge_state_t st_reg;
  lvm_edge_state_t st_next;
  logic [1:0] hit_now;

  // ---------------------------------------------------------------
  // Per-pin edge qualification
  // ---------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_pin
      logic rise;
      logic fall;
      lvm_edge_t sel;
      logic hit;
      assign sel = lvm_edge_t'(edge_bus.edge_sel[2*gi +: 2]);
      assign rise = st_reg.s2[gi] & ~st_reg.prev[gi];
      assign fall = ~st_reg.s2[gi] & st_reg.prev[gi];
      always_comb
      begin
        case (sel)
          LVM_EDGE_RISE: hit = rise;
          LVM_EDGE_FALL: hit = fall;
          LVM_EDGE_BOTH: hit = rise | fall;
          default: hit = 1'b0;
        endcase
      end
      assign hit_now[gi] = hit;
    end
  endgenerate

  always_comb
  begin
    st_next = st_reg;
    st_next.s1 = i_ext_irq_pin;
    st_next.s2 = st_reg.s1;
    st_next.prev = st_reg.s2;
    st_next.hit = hit_now;
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign edge_bus.edge_hit = st_reg.hit;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_edge_rise: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    (st_reg.s2[0] && !st_reg.prev[0] && edge_bus.edge_sel[1:0] == 2'b01)
      |=> edge_bus.edge_hit[0])
    else $error("rising edge on pin 0 not flagged");
  a_edge_off: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    (edge_bus.edge_sel[3:2] == 2'b00) |=> !edge_bus.edge_hit[1])
    else $error("pin 1 flagged while detection off");
endmodule // lvm_edge_det
`default_nettype wire

// file: rtl/lvm_monitor_irq.sv
`timescale 1ns/1ps
`default_nettype none
module lvm_monitor_irq (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // Special-purpose data memory port
  input wire logic i_sfr_wr,
  input wire logic i_sfr_rd,
  input wire logic [lvm_pkg::LVM_AW-1:0] i_sfr_addr,
  input wire logic [7:0] i_sfr_wdata,
  output logic [7:0] o_sfr_rdata,
  // Analog monitor front end
  input wire logic i_cmp_supply_low,
  input wire logic i_cmp_ext_low,
  input wire logic i_lvr_enable,
  input wire logic i_sleep,
  output logic o_monitor_on,
  output logic o_bandgap_on,
  output logic [2:0] o_threshold_select,
  output logic o_use_ext_input,
  // External interrupt pins
  input wire logic [1:0] i_ext_irq_pin,
  // Peripheral events
  input wire logic [lvm_pkg::LVM_NSRC-1:0] i_src_evt,
  // Core side
  output logic o_irq_req,
  output logic [3:0] o_irq_vector,
  input wire logic i_irq_ack,
  output logic o_lv_wake
);
  import lvm_pkg::*;

  localparam logic [LVM_LV_CNT_W-1:0] LV_DELAY = LVM_LV_CNT_W'(LVM_LV_DELAY_CYC);
  localparam int LV_DELAY_INT = LVM_LV_DELAY_CYC;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [2:0] thr;
    logic reference_output_enable;
    logic mon_en;
    logic [1:0] cmp_s1;
    logic [1:0] cmp_s2;
    logic [LVM_LV_CNT_W-1:0] lv_cnt;
    logic [3:0] edge_sel;
    logic gie;
    logic [LVM_NPRI-1:0] pe;
    logic [LVM_NPRI-1:0] pf;
    logic [3:0] sec_e;
    logic [3:0] sec_f;
    logic dee;
    logic def;
    logic low_voltage_irq_enable;
    logic low_voltage_request_flag;
    logic [7:0] rdata;
    logic req;
    logic [3:0] vec;
    logic wake;
  } lvm_state_t;

  lvm_state_t st_reg;
  lvm_state_t st_next;

  logic mon_active;
  logic lv_raw;
  logic low_voltage_out_flag;
  logic lv_set;
  logic wr_ctl;
  logic wr_edge;
  logic wr_pa;
  logic wr_pb;
  logic wr_pc;
  logic wr_ga;
  logic wr_gb;
  logic wr_gc;
  logic ack_take;
  logic [7:0] rd_mux;
  logic [LVM_NPRI-1:0] pend;
  logic [LVM_NPRI-1:0] pset;
  logic [LVM_NPRI-1:0] pf_wr;
  logic [LVM_NPRI-1:0] ack_clr;
  logic [3:0] pri_idx;
  logic [3:0] sec_set;
  logic [3:0] sec_wr;

  lvm_edge_if edge_bus ();

  // ---------------------------------------------------------------
  // Pin edge detection
  // ---------------------------------------------------------------
  lvm_edge_det u_edge (
    .i_core_clk (i_core_clk),
    .i_rst_n (i_rst_n),
    .i_ext_irq_pin (i_ext_irq_pin),
    .edge_bus (edge_bus.det)
  );

  assign edge_bus.edge_sel = st_reg.edge_sel;

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  assign wr_ctl = i_sfr_wr && (i_sfr_addr == LVM_ADDR_CTL);
  assign wr_edge = i_sfr_wr && (i_sfr_addr == LVM_ADDR_EDGE);
  assign wr_pa = i_sfr_wr && (i_sfr_addr == LVM_ADDR_PRI_A);
  assign wr_pb = i_sfr_wr && (i_sfr_addr == LVM_ADDR_PRI_B);
  assign wr_pc = i_sfr_wr && (i_sfr_addr == LVM_ADDR_PRI_C);
  assign wr_ga = i_sfr_wr && (i_sfr_addr == LVM_ADDR_GRP_A);
  assign wr_gb = i_sfr_wr && (i_sfr_addr == LVM_ADDR_GRP_B);
  assign wr_gc = i_sfr_wr && (i_sfr_addr == LVM_ADDR_GRP_C);
  assign ack_take = i_irq_ack && st_reg.req;

  // ---------------------------------------------------------------
  // Monitor
  // ---------------------------------------------------------------
  assign mon_active = st_reg.mon_en & ~i_sleep;
  // Code zero routes the external pin comparator instead of supply
  assign lv_raw = (st_reg.thr == LVM_THR_EXT) ? st_reg.cmp_s2[1] : st_reg.cmp_s2[0];
  assign low_voltage_out_flag = mon_active & lv_raw;
  // Counter restarts on every drop, so chatter near the level is harmless
  assign lv_set = low_voltage_out_flag && (st_reg.lv_cnt == LV_DELAY - 1'b1);

  assign o_monitor_on = mon_active;
  assign o_bandgap_on = st_reg.reference_output_enable | st_reg.mon_en | i_lvr_enable;
  assign o_threshold_select = st_reg.thr;
  assign o_use_ext_input = (st_reg.thr == LVM_THR_EXT);

  // ---------------------------------------------------------------
  // Request sources
  // ---------------------------------------------------------------
  assign sec_set = {i_src_evt[LVM_S_STMA], i_src_evt[LVM_S_STMP],
                    i_src_evt[LVM_S_CTMA], i_src_evt[LVM_S_CTMP]};

  always_comb
  begin
    pset = '0;
    pset[LVM_P_EXT_IRQ_PIN_0] = edge_bus.edge_hit[0];
    pset[LVM_P_EXT_IRQ_PIN_1] = edge_bus.edge_hit[1];
    pset[LVM_P_ADC] = i_src_evt[LVM_S_ADC];
    pset[LVM_P_SPI] = i_src_evt[LVM_S_SPI];
    pset[LVM_P_TB0] = i_src_evt[LVM_S_TB0];
    pset[LVM_P_TB1] = i_src_evt[LVM_S_TB1];
    pset[LVM_P_UART] = i_src_evt[LVM_S_UART];
    // Shared channels follow their enabled secondary flags
    pset[LVM_P_MF0] = |(st_reg.sec_f[1:0] & st_reg.sec_e[1:0]);
    pset[LVM_P_MF1] = |(st_reg.sec_f[3:2] & st_reg.sec_e[3:2]);
    pset[LVM_P_MF2] = (st_reg.def & st_reg.dee) | (st_reg.low_voltage_request_flag & st_reg.low_voltage_irq_enable);
  end

  // ---------------------------------------------------------------
  // Priority
  // ---------------------------------------------------------------
  assign pend = st_reg.pe & st_reg.pf;

  always_comb
  begin
    pri_idx = 4'h0;
    for (int i = LVM_NPRI - 1; i >= 0; i--)
    begin
      if (pend[i])
        pri_idx = 4'(i);
    end
  end

  always_comb
  begin
    ack_clr = '0;
    for (int i = 0; i < LVM_NPRI; i++)
    begin
      if (ack_take && (st_reg.vec == 4'(i)))
        ack_clr[i] = 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Register writes
  // ---------------------------------------------------------------
  always_comb
  begin
    pf_wr = st_reg.pf;
    if (wr_pa)
    begin
      pf_wr[LVM_P_EXT_IRQ_PIN_0] = i_sfr_wdata[LVM_PRI_A_FLG_LSB];
      pf_wr[LVM_P_EXT_IRQ_PIN_1] = i_sfr_wdata[LVM_PRI_A_FLG_LSB + 1];
      pf_wr[LVM_P_ADC] = i_sfr_wdata[LVM_PRI_A_FLG_LSB + 2];
    end
    if (wr_pb)
    begin
      pf_wr[LVM_P_MF0] = i_sfr_wdata[LVM_FLG_LSB];
      pf_wr[LVM_P_MF1] = i_sfr_wdata[LVM_FLG_LSB + 1];
      pf_wr[LVM_P_MF2] = i_sfr_wdata[LVM_FLG_LSB + 2];
      pf_wr[LVM_P_SPI] = i_sfr_wdata[LVM_FLG_LSB + 3];
    end
    if (wr_pc)
    begin
      pf_wr[LVM_P_TB0] = i_sfr_wdata[LVM_FLG_LSB];
      pf_wr[LVM_P_TB1] = i_sfr_wdata[LVM_FLG_LSB + 1];
      pf_wr[LVM_P_UART] = i_sfr_wdata[LVM_FLG_LSB + 2];
    end
    sec_wr = st_reg.sec_f;
    if (wr_ga)
      sec_wr[1:0] = i_sfr_wdata[LVM_FLG_LSB +: 2];
    if (wr_gb)
      sec_wr[3:2] = i_sfr_wdata[LVM_FLG_LSB +: 2];
  end

  always_comb
  begin
    st_next = st_reg;
    st_next.cmp_s1 = {i_cmp_ext_low, i_cmp_supply_low};
    st_next.cmp_s2 = st_reg.cmp_s1;
    if (!low_voltage_out_flag)
      st_next.lv_cnt = '0;
    else if (st_reg.lv_cnt != LV_DELAY)
      st_next.lv_cnt = st_reg.lv_cnt + 1'b1;
    if (wr_ctl)
    begin
      st_next.thr = i_sfr_wdata[LVM_CTL_THR_LSB +: 3];
      st_next.reference_output_enable = i_sfr_wdata[LVM_CTL_REFERENCE_OUTPUT_ENABLE_BIT];
      st_next.mon_en = i_sfr_wdata[LVM_CTL_EN_BIT];
    end
    if (wr_edge)
      st_next.edge_sel = i_sfr_wdata[3:0];
    if (wr_pa)
    begin
      st_next.gie = i_sfr_wdata[LVM_PRI_A_GIE_BIT];
      st_next.pe[LVM_P_EXT_IRQ_PIN_0] = i_sfr_wdata[LVM_PRI_A_EN_LSB];
      st_next.pe[LVM_P_EXT_IRQ_PIN_1] = i_sfr_wdata[LVM_PRI_A_EN_LSB + 1];
      st_next.pe[LVM_P_ADC] = i_sfr_wdata[LVM_PRI_A_EN_LSB + 2];
    end
    if (wr_pb)
    begin
      st_next.pe[LVM_P_MF0] = i_sfr_wdata[LVM_ENA_LSB];
      st_next.pe[LVM_P_MF1] = i_sfr_wdata[LVM_ENA_LSB + 1];
      st_next.pe[LVM_P_MF2] = i_sfr_wdata[LVM_ENA_LSB + 2];
      st_next.pe[LVM_P_SPI] = i_sfr_wdata[LVM_ENA_LSB + 3];
    end
    if (wr_pc)
    begin
      st_next.pe[LVM_P_TB0] = i_sfr_wdata[LVM_ENA_LSB];
      st_next.pe[LVM_P_TB1] = i_sfr_wdata[LVM_ENA_LSB + 1];
      st_next.pe[LVM_P_UART] = i_sfr_wdata[LVM_ENA_LSB + 2];
    end
    if (wr_ga)
      st_next.sec_e[1:0] = i_sfr_wdata[LVM_ENA_LSB +: 2];
    if (wr_gb)
      st_next.sec_e[3:2] = i_sfr_wdata[LVM_ENA_LSB +: 2];
    if (wr_gc)
    begin
      st_next.low_voltage_irq_enable = i_sfr_wdata[LVM_ENA_LSB];
      st_next.dee = i_sfr_wdata[LVM_ENA_LSB + 1];
    end
    // Hardware set beats a software clear in the same cycle
    st_next.pf = (pf_wr & ~ack_clr) | pset;
    st_next.sec_f = sec_wr | sec_set;
    st_next.low_voltage_request_flag = (wr_gc ? i_sfr_wdata[LVM_FLG_LSB] : st_reg.low_voltage_request_flag) | lv_set;
    st_next.def = (wr_gc ? i_sfr_wdata[LVM_FLG_LSB + 1] : st_reg.def) | i_src_evt[LVM_S_EEP];
    // Wake only on a fresh set; a preset flag suppresses it
    st_next.wake = lv_set & ~st_reg.low_voltage_request_flag;
    if (ack_take)
      st_next.gie = 1'b0;
    st_next.req = st_reg.gie & (|pend) & ~ack_take;
    st_next.vec = pri_idx;
    if (i_sfr_rd)
      st_next.rdata = rd_mux;
  end

  // ---------------------------------------------------------------
  // Read mux
  // ---------------------------------------------------------------
  always_comb
  begin
    case (i_sfr_addr)
      LVM_ADDR_CTL:
        rd_mux = {2'b00, low_voltage_out_flag, st_reg.mon_en, st_reg.reference_output_enable, st_reg.thr};
      LVM_ADDR_EDGE:
        rd_mux = {4'h0, st_reg.edge_sel};
      LVM_ADDR_PRI_A:
        rd_mux = {1'b0, st_reg.pf[LVM_P_ADC], st_reg.pf[LVM_P_EXT_IRQ_PIN_1], st_reg.pf[LVM_P_EXT_IRQ_PIN_0],
                  st_reg.pe[LVM_P_ADC], st_reg.pe[LVM_P_EXT_IRQ_PIN_1], st_reg.pe[LVM_P_EXT_IRQ_PIN_0],
                  st_reg.gie};
      LVM_ADDR_PRI_B:
        rd_mux = {st_reg.pf[LVM_P_SPI], st_reg.pf[LVM_P_MF2], st_reg.pf[LVM_P_MF1],
                  st_reg.pf[LVM_P_MF0], st_reg.pe[LVM_P_SPI], st_reg.pe[LVM_P_MF2],
                  st_reg.pe[LVM_P_MF1], st_reg.pe[LVM_P_MF0]};
      LVM_ADDR_PRI_C:
        rd_mux = {1'b0, st_reg.pf[LVM_P_UART], st_reg.pf[LVM_P_TB1], st_reg.pf[LVM_P_TB0],
                  1'b0, st_reg.pe[LVM_P_UART], st_reg.pe[LVM_P_TB1], st_reg.pe[LVM_P_TB0]};
      LVM_ADDR_GRP_A:
        rd_mux = {2'b00, st_reg.sec_f[1:0], 2'b00, st_reg.sec_e[1:0]};
      LVM_ADDR_GRP_B:
        rd_mux = {2'b00, st_reg.sec_f[3:2], 2'b00, st_reg.sec_e[3:2]};
      LVM_ADDR_GRP_C:
        rd_mux = {2'b00, st_reg.def, st_reg.low_voltage_request_flag, 2'b00, st_reg.dee, st_reg.low_voltage_irq_enable};
      default:
        rd_mux = LVM_REG_RST;
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // Gated by live enable so a software clear blocks at once
  assign o_irq_req = st_reg.req & st_reg.gie;
  assign o_irq_vector = st_reg.vec;
  assign o_sfr_rdata = st_reg.rdata;
  assign o_lv_wake = st_reg.wake;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_ack;
    i_irq_ack && st_reg.req;
  endsequence
  sequence s_blocked;
    !st_reg.gie ##0 !o_irq_req;
  endsequence
  sequence s_wake_pulse;
    o_lv_wake ##1 !o_lv_wake;
  endsequence

  a_ack_gie_off: assert property (
    s_ack |=> s_blocked)
    else $error("global enable survived a taken vector");
  a_gie_blocks: assert property (
    !st_reg.gie |=> !st_reg.req)
    else $error("request raised with global enable clear");
  a_lvf_delay: assert property (
    ($rose(st_reg.low_voltage_request_flag) && !$past(wr_gc)) |-> ($past(st_reg.lv_cnt) == LV_DELAY_INT - 1))
    else $error("low-voltage flag set before delay");
  a_lvf_after: assert property (
    (low_voltage_out_flag && st_reg.lv_cnt == LV_DELAY_INT - 1) |=> st_reg.low_voltage_request_flag)
    else $error("low-voltage flag missed after delay");
  a_wake_once: assert property (
    (lv_set && !st_reg.low_voltage_request_flag) |=> s_wake_pulse)
    else $error("wake pulse missing or stuck");
  a_sleep_off: assert property (
    i_sleep |-> (!o_monitor_on && !low_voltage_out_flag))
    else $error("monitor active in sleep");
  a_bandgap_on: assert property (
    (st_reg.reference_output_enable || st_reg.mon_en || i_lvr_enable) |-> o_bandgap_on)
    else $error("bandgap off while needed");
  a_rsvd_ctl: assert property (
    (i_sfr_rd && i_sfr_addr == LVM_ADDR_CTL) |=> (o_sfr_rdata[7:6] == 2'b00))
    else $error("control reserved bits nonzero");
  a_rsvd_edge: assert property (
    (i_sfr_rd && i_sfr_addr == LVM_ADDR_EDGE) |=> (o_sfr_rdata[7:4] == 4'h0))
    else $error("edge register reserved bits nonzero");
  a_ext_source: assert property (
    (st_reg.thr == 3'h0) |-> o_use_ext_input)
    else $error("external input not selected for code zero");
  a_flag_holds: assert property (
    (st_reg.pf[LVM_P_EXT_IRQ_PIN_0] && !wr_pa && !ack_clr[LVM_P_EXT_IRQ_PIN_0]) |=> st_reg.pf[LVM_P_EXT_IRQ_PIN_0])
    else $error("pin 0 flag dropped without clear");
endmodule // lvm_monitor_irq
`default_nettype wire

// file: dv/lvm_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module lvm_core_model (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // Controller side
  input wire logic i_irq_req,
  input wire logic [3:0] i_irq_vector,
  input wire logic [3:0] i_lag,
  output logic o_irq_ack,
  output logic [3:0] o_last_vec
);
  logic [3:0] wait_reg;
  // Acks only while a request stands; lag lets the core be slow
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      wait_reg <= 4'h0;
      o_irq_ack <= 1'b0;
      o_last_vec <= 4'hF;
    end
    else if (o_irq_ack)
    begin
      o_irq_ack <= 1'b0;
      wait_reg <= 4'h0;
      o_last_vec <= i_irq_vector;
    end
    else if (i_irq_req && wait_reg == i_lag)
      o_irq_ack <= 1'b1;
    else if (i_irq_req)
      wait_reg <= wait_reg + 4'h1;
    else
      wait_reg <= 4'h0;
  end
endmodule // lvm_core_model
`default_nettype wire

// file: dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import lvm_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic sup_low = 1'b0;
  logic ext_low = 1'b0;
  logic low_voltage_reset = 1'b0;
  logic sleep = 1'b0;
  logic mon_on, bg_on, use_ext, req, ack, wake;
  logic [2:0] thr;
  logic [1:0] pins = 2'h0;
  logic [9:0] evt = 10'h000;
  logic [3:0] vec, last_vec;
  logic [3:0] lag = 4'h0;
  int mismatches = 0;
  int checks = 0;
  int wakes = 0;
  always #10 clk = ~clk;
  lvm_monitor_irq i_dut (.i_core_clk(clk), .i_rst_n(rst_n), .i_sfr_wr(wr), .i_sfr_rd(rd),
    .i_sfr_addr(addr), .i_sfr_wdata(wdata), .o_sfr_rdata(rdata), .i_cmp_supply_low(sup_low),
    .i_cmp_ext_low(ext_low), .i_lvr_enable(low_voltage_reset), .i_sleep(sleep), .o_monitor_on(mon_on),
    .o_bandgap_on(bg_on), .o_threshold_select(thr), .o_use_ext_input(use_ext),
    .i_ext_irq_pin(pins), .i_src_evt(evt), .o_irq_req(req), .o_irq_vector(vec),
    .i_irq_ack(ack), .o_lv_wake(wake));
  lvm_core_model i_core (.i_core_clk(clk), .i_rst_n(rst_n), .i_irq_req(req),
    .i_irq_vector(vec), .i_lag(lag), .o_irq_ack(ack), .o_last_vec(last_vec));
  always @(negedge clk)
    if (wake === 1'b1)
      wakes++;
  // ---------------------------------------------------------------
  // Access and compare tasks
  // ---------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    cyc(1);
    addr = a;
    wdata = d;
    wr = 1'b1;
    cyc(1);
    wr = 1'b0;
  endtask
  task automatic cmp8(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("Error at %0t: got %h, expected %h", $time, g, e);
    end
  endtask
  task automatic chk(input logic [7:0] a, input logic [7:0] e);
    cyc(1);
    addr = a;
    rd = 1'b1;
    cyc(1);
    rd = 1'b0;
    cmp8(rdata, e);
  endtask
  task automatic end_sim;
    $display("Checks %0d, mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    #200000;
    mismatches++;
    end_sim;
  end
  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial
  begin
    cyc(8);
    rst_n = 1'b1;
    for (int a = 0; a < 9; a++)
      chk(8'(a), 8'h00);
    cmp8(8'({bg_on, use_ext, mon_on}), 8'h02);
    wreg(LVM_ADDR_CTL, 8'hFF);
    chk(LVM_ADDR_CTL, 8'h1F);
    cmp8(8'({thr, use_ext, mon_on, bg_on}), 8'h3B);
    wreg(LVM_ADDR_CTL, 8'h08);
    cmp8(8'({mon_on, bg_on}), 8'h01);
    wreg(LVM_ADDR_CTL, 8'h00);
    low_voltage_reset = 1'b1;
    cyc(1);
    cmp8(8'({bg_on, use_ext}), 8'h03);
    low_voltage_reset = 1'b0;
    wreg(LVM_ADDR_EDGE, 8'hFF);
    chk(LVM_ADDR_EDGE, 8'h0F);
    wreg(8'h08, 8'hFF);
    chk(8'h08, 8'h00);
    $display("Test registers done");
    for (int p = 0; p < 2; p++)
      for (int c = 0; c < 4; c++)
      begin
        wreg(LVM_ADDR_EDGE, 8'(c << (2 * p)));
        wreg(LVM_ADDR_PRI_A, 8'h00);
        pins[p] = 1'b1;
        cyc(6);
        chk(LVM_ADDR_PRI_A, c[0] ? 8'(8'h10 << p) : 8'h00);
        wreg(LVM_ADDR_PRI_A, 8'h00);
        pins[p] = 1'b0;
        cyc(6);
        chk(LVM_ADDR_PRI_A, c[1] ? 8'(8'h10 << p) : 8'h00);
      end
    $display("Test edges done");
    lag = 4'h3;
    wreg(LVM_ADDR_EDGE, 8'h01);
    wreg(LVM_ADDR_PRI_A, 8'h02);
    pins[0] = 1'b1;
    cyc(6);
    cmp8(8'(req), 8'h00);
    chk(LVM_ADDR_PRI_A, 8'h12);
    pins[0] = 1'b0;
    wreg(LVM_ADDR_PRI_A, 8'h13);
    cyc(10);
    chk(LVM_ADDR_PRI_A, 8'h02);
    cmp8(8'(last_vec), 8'(LVM_P_EXT_IRQ_PIN_0));
    $display("Test vector done");
    lag = 4'h0;
    wreg(LVM_ADDR_CTL, 8'h10);
    ext_low = 1'b1;
    cyc(5);
    chk(LVM_ADDR_CTL, 8'h30);
    sleep = 1'b1;
    cyc(5);
    cmp8(8'(mon_on), 8'h00);
    chk(LVM_ADDR_CTL, 8'h10);
    sleep = 1'b0;
    ext_low = 1'b0;
    // Preset flag so the first low-voltage event cannot wake the core
    wreg(LVM_ADDR_GRP_C, 8'h10);
    wreg(LVM_ADDR_CTL, 8'h11);
    cmp8(8'(thr), 8'h01);
    sup_low = 1'b1;
    cyc(5);
    chk(LVM_ADDR_CTL, 8'h31);
    cyc(760);
    cmp8(8'(wakes), 8'h00);
    evt = 10'h200;
    cyc(1);
    evt = 10'h000;
    chk(LVM_ADDR_GRP_C, 8'h30);
    wreg(LVM_ADDR_PRI_B, 8'h04);
    wreg(LVM_ADDR_PRI_A, 8'h01);
    wreg(LVM_ADDR_GRP_C, 8'h01);
    sup_low = 1'b0;
    cyc(5);
    chk(LVM_ADDR_CTL, 8'h11);
    sup_low = 1'b1;
    cyc(740);
    chk(LVM_ADDR_GRP_C, 8'h01);
    cyc(20);
    chk(LVM_ADDR_GRP_C, 8'h11);
    cmp8(8'(wakes), 8'h01);
    cmp8(8'(last_vec), 8'(LVM_P_MF2));
    chk(LVM_ADDR_PRI_A, 8'h00);
    chk(LVM_ADDR_PRI_B, 8'h44);
    $display("Test monitor done");
    evt = 10'h1FF;
    cyc(1);
    evt = 10'h000;
    chk(LVM_ADDR_GRP_A, 8'h30);
    chk(LVM_ADDR_GRP_B, 8'h30);
    chk(LVM_ADDR_PRI_A, 8'h40);
    chk(LVM_ADDR_PRI_C, 8'h70);
    chk(LVM_ADDR_PRI_B, 8'hC4);
    wreg(LVM_ADDR_GRP_A, 8'h31);
    cyc(2);
    chk(LVM_ADDR_PRI_B, 8'hD4);
    $display("Test sources done");
    end_sim;
  end
endmodule // testbench
`default_nettype wire
